// *** verilog/gam_pkg.sv ***
package gam_pkg;
   // Register offsets on the serial register port.
   localparam logic [7:0] OFF_TARGET_ADDR = 8'h09;
   localparam logic [7:0] OFF_PIN_FUNC_SEL = 8'h0b;
   localparam logic [7:0] OFF_ADDR_UNLOCK_KEY = 8'h0d;

   // Field positions and widths.
   localparam int SEL_W = 5;
   localparam int PIN0_SEL_LSB = 0;
   localparam int PIN1_SEL_LSB = 8;
   localparam int SEL_STRIDE = 8;
   localparam int ADDR_W = 7;
   localparam int ADDR_LSB = 1;
   localparam logic [15:0] PIN_FUNC_SEL_MASK = 16'h1f1f;

   // Values after reset.
   localparam logic [15:0] PIN_FUNC_SEL_RST = 16'h0000;
   localparam logic [15:0] ADDR_UNLOCK_KEY_RST = 16'h0000;
   localparam logic [6:0] TARGET_ADDR_RST = 7'h32;

   // Pin function select codes.
   localparam logic [4:0] SEL_LEGACY = 5'h00;
   localparam logic [4:0] SEL_CFG_IRQ = 5'h01;
   localparam logic [4:0] SEL_WINDOW = 5'h02;
   localparam logic [4:0] SEL_PULSE_A = 5'h05;
   localparam logic [4:0] SEL_PULSE_B = 5'h06;
   localparam logic [4:0] SEL_PULSE_AB = 5'h07;
   localparam logic [4:0] SEL_DATA_A = 5'h0c;
   localparam logic [4:0] SEL_DATA_B = 5'h0d;
   localparam logic [4:0] SEL_DATA_AB = 5'h0e;
   localparam logic [4:0] SEL_TOGGLE = 5'h0f;
   localparam logic [4:0] SEL_LOW = 5'h10;
   localparam logic [4:0] SEL_HIGH = 5'h11;
   localparam logic [4:0] SEL_OSC = 5'h13;

   // Address unlock key values.
   localparam logic [15:0] KEY_ALWAYS = 16'h04ad;
   localparam logic [15:0] KEY_IF_PIN0 = 16'h44ad;
   localparam logic [15:0] KEY_IF_PIN1 = 16'h84ad;
   localparam logic [15:0] KEY_IF_BOTH = 16'hc4ad;

   // Length of the oscillator synchroniser.
   localparam int SYNC_STAGES = 2;

   // True when a target address write may be taken.
   function automatic logic addr_change_ok(input logic [15:0] key,
                                           input logic pin0,
                                           input logic pin1);
      addr_change_ok = (key == KEY_ALWAYS) ||
                       ((key == KEY_IF_PIN0) && pin0) ||
                       ((key == KEY_IF_PIN1) && pin1) ||
                       ((key == KEY_IF_BOTH) && pin0 && pin1);
   endfunction

   // True for every code that has a defined pin behaviour.
   function automatic logic sel_supported(input logic [4:0] sel);
      sel_supported = (sel <= SEL_WINDOW) ||
                      ((sel >= SEL_PULSE_A) && (sel <= SEL_PULSE_AB)) ||
                      ((sel >= SEL_DATA_A) && (sel <= SEL_HIGH)) ||
                      (sel == SEL_OSC);
   endfunction
endpackage

// *** verilog/gam_pin_select.sv ***
module gam_pin_select (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [4:0] sel,
   input wire logic legacy_src,
   input wire logic cfg_irq,
   input wire logic irq_invert,
   input wire logic window,
   input wire logic pulse_a,
   input wire logic pulse_b,
   input wire logic data_a,
   input wire logic data_b,
   input wire logic sample_strobe,
   input wire logic osc,
   output logic pin_q
);
   logic toggle_q;
   logic toggle_d;
   logic pin_d;

   always_comb begin
      // The toggle runs in every mode so that a switch to it starts cleanly.
      toggle_d = sample_strobe ? ~toggle_q : toggle_q;
      case (sel)
         // [R1] Legacy interrupt source.
         gam_pkg::SEL_LEGACY: pin_d = legacy_src ^ irq_invert;
         // [R2] Configured interrupt source.
         gam_pkg::SEL_CFG_IRQ: pin_d = cfg_irq ^ irq_invert;
         gam_pkg::SEL_WINDOW: pin_d = window;
         gam_pkg::SEL_PULSE_A: pin_d = pulse_a;
         gam_pkg::SEL_PULSE_B: pin_d = pulse_b;
         gam_pkg::SEL_PULSE_AB: pin_d = pulse_a | pulse_b;
         gam_pkg::SEL_DATA_A: pin_d = data_a;
         gam_pkg::SEL_DATA_B: pin_d = data_b;
         gam_pkg::SEL_DATA_AB: pin_d = data_a | data_b;
         // [R6] Half-rate toggle, pin 0.
         // [R7] Half-rate toggle, pin 1.
         gam_pkg::SEL_TOGGLE: pin_d = toggle_d;
         gam_pkg::SEL_LOW: pin_d = 1'b0;
         gam_pkg::SEL_HIGH: pin_d = 1'b1;
         gam_pkg::SEL_OSC: pin_d = osc;
         // [R14] Unsupported codes low.
         default: pin_d = 1'b0;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         toggle_q <= 1'b0;
         pin_q <= 1'b0;
      end else begin
         toggle_q <= toggle_d;
         pin_q <= pin_d;
      end
   end
endmodule

// *** verilog/gam_pin_mux.sv ***
// Summary of operation
// [R1] Select 0 (reset) puts the legacy interrupt behaviour on pin 0.
// [R2] Select 1 puts the configured interrupt signal on pin 0.
// [R3] Select 2 drives pin 0 high from first slot start to last slot end.
// [R4] Selects 5, 6, 7 give slot A, slot B, or both pulse trains.
// [R5] Selects 12, 13, 14 flag data cycles for slot A, B, or either.
// [R6] Select 15 inverts pin 0 once per sample.
// [R7] Select 15 inverts pin 1 once per sample.
// [R8] Codes 16, 17, 19 give constant low, constant high, 32 kHz clock.
// [R9] Software writes only the listed select codes.
// [R10] Target address changes only when the unlock key permits it.
// [R11] Key 04AD always; 44AD, 84AD, C4AD need pin 0, pin 1, both high.
// [R12] Host writes 0xAD in the upper byte of an address write.
// [R13] Pin 0 interrupt is active high with polarity 0, low with 1.
// [R14] Unsupported select codes drive the pin low.
module gam_pin_mux (
   input wire logic CORE_CLK,
   input wire logic RESET_N,
   input wire logic [7:0] REG_ADDR,
   input wire logic REG_WR,
   input wire logic [15:0] REG_WDATA,
   output logic [15:0] REG_RDATA,
   input wire logic LEGACY_IRQ,
   input wire logic LEGACY_DATA_OUT,
   input wire logic CFG_IRQ,
   input wire logic PIN0_POLARITY,
   input wire logic FIRST_SLOT_START,
   input wire logic LAST_SLOT_END,
   input wire logic PULSE_A,
   input wire logic PULSE_B,
   input wire logic DATA_CYCLE_A,
   input wire logic DATA_CYCLE_B,
   input wire logic SAMPLE_STROBE,
   input wire logic OSC_32K,
   output logic AUX_PIN_0,
   output logic AUX_PIN_1,
   output logic [6:0] TARGET_ADDR
);
   logic [15:0] sel_q;
   logic [15:0] sel_d;
   logic [15:0] key_q;
   logic [15:0] key_d;
   logic [6:0] addr_q;
   logic [6:0] addr_d;
   logic [15:0] rdata_q;
   logic [15:0] rdata_d;
   logic window_q;
   logic window_d;
   logic [gam_pkg::SYNC_STAGES-1:0] osc_sync_q;
   logic [gam_pkg::SYNC_STAGES-1:0] osc_sync_d;
   logic [1:0] pin_q;
   logic [1:0] legacy_src;
   logic addr_wr;
   logic addr_ok;

   assign legacy_src = {LEGACY_DATA_OUT, LEGACY_IRQ};
   assign addr_wr = REG_WR && (REG_ADDR == gam_pkg::OFF_TARGET_ADDR);
   assign addr_ok = gam_pkg::addr_change_ok(key_q, pin_q[0], pin_q[1]);

   always_comb begin
      sel_d = sel_q;
      key_d = key_q;
      addr_d = addr_q;
      if (REG_WR && (REG_ADDR == gam_pkg::OFF_PIN_FUNC_SEL)) begin
         sel_d = REG_WDATA & gam_pkg::PIN_FUNC_SEL_MASK;
      end
      if (REG_WR && (REG_ADDR == gam_pkg::OFF_ADDR_UNLOCK_KEY)) begin
         key_d = REG_WDATA;
      end
      // [R10] Gated address change.
      // [R11] Key checks the pin levels now driven.
      if (addr_wr && addr_ok) begin
         addr_d = REG_WDATA[gam_pkg::ADDR_LSB +: gam_pkg::ADDR_W];
      end
      unique case (REG_ADDR)
         gam_pkg::OFF_PIN_FUNC_SEL: rdata_d = sel_q;
         gam_pkg::OFF_ADDR_UNLOCK_KEY: rdata_d = key_q;
         gam_pkg::OFF_TARGET_ADDR: rdata_d = {8'h00, addr_q, 1'b0};
         default: rdata_d = 16'h0000;
      endcase
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RESET_N) begin
         sel_q <= gam_pkg::PIN_FUNC_SEL_RST;
         key_q <= gam_pkg::ADDR_UNLOCK_KEY_RST;
         addr_q <= gam_pkg::TARGET_ADDR_RST;
         rdata_q <= 16'h0000;
      end else begin
         sel_q <= sel_d;
         key_q <= key_d;
         addr_q <= addr_d;
         rdata_q <= rdata_d;
      end
   end

   always_comb begin
      // [R3] Window set and clear.
      // A start and an end in one cycle is an empty window, so the end wins.
      window_d = window_q;
      if (FIRST_SLOT_START) begin
         window_d = 1'b1;
      end
      if (LAST_SLOT_END) begin
         window_d = 1'b0;
      end
      // The oscillator runs on its own clock and is resynchronised here.
      osc_sync_d = {osc_sync_q[gam_pkg::SYNC_STAGES-2:0], OSC_32K};
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RESET_N) begin
         window_q <= 1'b0;
         osc_sync_q <= '0;
      end else begin
         window_q <= window_d;
         osc_sync_q <= osc_sync_d;
      end
   end

   // [R13] Polarity inverts pin 0 only.
   // [R4] Per-pin selectors.
   // [R5] Data cycle flags.
   // [R8] Constants and oscillator.
   for (genvar i = 0; i < 2; i++) begin : g_pin
      gam_pin_select u_sel (
         .clk(CORE_CLK),
         .rst_n(RESET_N),
         .sel(sel_q[i*gam_pkg::SEL_STRIDE +: gam_pkg::SEL_W]),
         .legacy_src(legacy_src[i]),
         .cfg_irq(CFG_IRQ),
         .irq_invert((i == 0) ? PIN0_POLARITY : 1'b0),
         .window(window_q),
         .pulse_a(PULSE_A),
         .pulse_b(PULSE_B),
         .data_a(DATA_CYCLE_A),
         .data_b(DATA_CYCLE_B),
         .sample_strobe(SAMPLE_STROBE),
         .osc(osc_sync_q[gam_pkg::SYNC_STAGES-1]),
         .pin_q(pin_q[i])
      );
   end

   assign AUX_PIN_0 = pin_q[0];
   assign AUX_PIN_1 = pin_q[1];
   assign TARGET_ADDR = addr_q;
   assign REG_RDATA = rdata_q;

   logic [4:0] sel0;
   logic [4:0] sel1;
   assign sel0 = sel_q[gam_pkg::PIN0_SEL_LSB +: gam_pkg::SEL_W];
   assign sel1 = sel_q[gam_pkg::PIN1_SEL_LSB +: gam_pkg::SEL_W];

   a_legacy_pin0: assert property ( // [R1]
      @(posedge CORE_CLK) disable iff (!RESET_N)
      (sel0 == 5'h00) |=> (AUX_PIN_0 == ($past(LEGACY_IRQ) ^ $past(PIN0_POLARITY))))
      else $error("Pin 0 does not follow the legacy interrupt.");

   a_cfg_irq_pin0: assert property ( // [R2]
      @(posedge CORE_CLK) disable iff (!RESET_N)
      (sel0 == 5'h01 && !PIN0_POLARITY) |=> (AUX_PIN_0 == $past(CFG_IRQ)))
      else $error("Pin 0 does not follow the configured interrupt.");

   a_polarity_low: assert property ( // [R13]
      @(posedge CORE_CLK) disable iff (!RESET_N)
      (sel0 == 5'h01 && PIN0_POLARITY) |=> (AUX_PIN_0 != $past(CFG_IRQ)))
      else $error("Pin 0 interrupt not inverted for active low.");

   a_window_open: assert property ( // [R3]
      @(posedge CORE_CLK) disable iff (!RESET_N)
      (sel0 == 5'h02 && FIRST_SLOT_START && !LAST_SLOT_END) ##1 (sel0 == 5'h02)
      |=> AUX_PIN_0)
      else $error("Pin 0 window did not open two cycles after slot start.");

   a_window_close: assert property ( // [R3]
      @(posedge CORE_CLK) disable iff (!RESET_N)
      (sel0 == 5'h02 && LAST_SLOT_END) ##1 (sel0 == 5'h02 && !FIRST_SLOT_START)
      |=> !AUX_PIN_0)
      else $error("Pin 0 window did not close after last slot end.");

   a_pulse_both: assert property ( // [R4]
      @(posedge CORE_CLK) disable iff (!RESET_N)
      (sel1 == 5'h07) |=> (AUX_PIN_1 == ($past(PULSE_A) | $past(PULSE_B))))
      else $error("Pin 1 does not carry both pulse trains.");

   a_pulse_a_only: assert property ( // [R4]
      @(posedge CORE_CLK) disable iff (!RESET_N)
      (sel0 == 5'h05) |=> (AUX_PIN_0 == $past(PULSE_A)))
      else $error("Pin 0 does not carry the slot A pulse train.");

   a_data_either: assert property ( // [R5]
      @(posedge CORE_CLK) disable iff (!RESET_N)
      (sel0 == 5'h0e) |=> (AUX_PIN_0 == ($past(DATA_CYCLE_A) | $past(DATA_CYCLE_B))))
      else $error("Pin 0 does not flag data cycles of either slot.");

   a_data_b_only: assert property ( // [R5]
      @(posedge CORE_CLK) disable iff (!RESET_N)
      (sel1 == 5'h0d) |=> (AUX_PIN_1 == $past(DATA_CYCLE_B)))
      else $error("Pin 1 does not flag slot B data cycles.");

   a_toggle_pin0: assert property ( // [R6]
      @(posedge CORE_CLK) disable iff (!RESET_N)
      (sel0 == 5'h0f) ##1 (sel0 == 5'h0f && SAMPLE_STROBE) |=> $changed(AUX_PIN_0))
      else $error("Pin 0 did not invert on a sample.");

   a_toggle_hold0: assert property ( // [R6]
      @(posedge CORE_CLK) disable iff (!RESET_N)
      (sel0 == 5'h0f) ##1 (sel0 == 5'h0f && !SAMPLE_STROBE) |=> $stable(AUX_PIN_0))
      else $error("Pin 0 changed without a sample.");

   a_toggle_pin1: assert property ( // [R7]
      @(posedge CORE_CLK) disable iff (!RESET_N)
      (sel1 == 5'h0f) ##1 (sel1 == 5'h0f && SAMPLE_STROBE) |=> $changed(AUX_PIN_1))
      else $error("Pin 1 did not invert on a sample.");

   a_const_levels: assert property ( // [R8]
      @(posedge CORE_CLK) disable iff (!RESET_N)
      (sel1 == 5'h10 || sel1 == 5'h11) |=> (AUX_PIN_1 == $past(sel1[0])))
      else $error("Pin 1 constant level wrong.");

   a_osc_route: assert property ( // [R8]
      @(posedge CORE_CLK) disable iff (!RESET_N)
      (sel0 == 5'h13) [*3] |-> (AUX_PIN_0 == $past(OSC_32K, 3)))
      else $error("Pin 0 does not carry the oscillator three cycles late.");

   a_unsupported_low: assert property ( // [R14]
      @(posedge CORE_CLK) disable iff (!RESET_N)
      !gam_pkg::sel_supported(sel1) |=> !AUX_PIN_1)
      else $error("Pin 1 not low under an unsupported code.");

   a_addr_locked: assert property ( // [R10]
      @(posedge CORE_CLK) disable iff (!RESET_N)
      (addr_wr && key_q == 16'h0000) |=> $stable(TARGET_ADDR))
      else $error("Target address changed without a key.");

   a_addr_always: assert property ( // [R11]
      @(posedge CORE_CLK) disable iff (!RESET_N)
      (addr_wr && key_q == 16'h04ad) |=> (TARGET_ADDR == $past(REG_WDATA[7:1])))
      else $error("Target address not taken under the always key.");

   a_addr_gated_pin0: assert property ( // [R11]
      @(posedge CORE_CLK) disable iff (!RESET_N)
      (addr_wr && key_q == 16'h44ad && !AUX_PIN_0) |=> $stable(TARGET_ADDR))
      else $error("Target address taken with pin 0 low.");

   a_addr_both_pins: assert property ( // [R11]
      @(posedge CORE_CLK) disable iff (!RESET_N)
      (addr_wr && key_q == 16'hc4ad && AUX_PIN_0 && AUX_PIN_1)
      |=> (TARGET_ADDR == $past(REG_WDATA[7:1])))
      else $error("Target address refused with both pins high.");

   a_read_select: assert property (
      @(posedge CORE_CLK) disable iff (!RESET_N)
      (REG_ADDR == 8'h0b && !REG_WR) |=> (REG_RDATA == $past(sel_q)))
      else $error("Select register read back wrong.");

   a_pulse_b_only: assert property ( // [R4]
      @(posedge CORE_CLK) disable iff (!RESET_N)
      (sel0 == 5'h06) |=> (AUX_PIN_0 == $past(PULSE_B)))
      else $error("Pin 0 does not carry the slot B pulse train.");

   a_data_a_only: assert property ( // [R5]
      @(posedge CORE_CLK) disable iff (!RESET_N)
      (sel0 == 5'h0c) |=> (AUX_PIN_0 == $past(DATA_CYCLE_A)))
      else $error("Pin 0 does not flag slot A data cycles.");

   a_toggle_hold1: assert property ( // [R7]
      @(posedge CORE_CLK) disable iff (!RESET_N)
      (sel1 == 5'h0f) ##1 (sel1 == 5'h0f && !SAMPLE_STROBE) |=> $stable(AUX_PIN_1))
      else $error("Pin 1 changed without a sample.");

   a_const_pin0: assert property ( // [R8]
      @(posedge CORE_CLK) disable iff (!RESET_N)
      (sel0 == 5'h10 || sel0 == 5'h11) |=> (AUX_PIN_0 == $past(sel0[0])))
      else $error("Pin 0 constant level wrong.");

   a_osc_pin1: assert property ( // [R8]
      @(posedge CORE_CLK) disable iff (!RESET_N)
      (sel1 == 5'h13) [*3] |-> (AUX_PIN_1 == $past(OSC_32K, 3)))
      else $error("Pin 1 does not carry the oscillator three cycles late.");

   a_unsupported_pin0: assert property ( // [R14]
      @(posedge CORE_CLK) disable iff (!RESET_N)
      !gam_pkg::sel_supported(sel0) |=> !AUX_PIN_0)
      else $error("Pin 0 not low under an unsupported code.");

   a_addr_bad_key: assert property ( // [R10]
      @(posedge CORE_CLK) disable iff (!RESET_N)
      (addr_wr && key_q != 16'h04ad && key_q != 16'h44ad && key_q != 16'h84ad
       && key_q != 16'hc4ad) |=> $stable(TARGET_ADDR))
      else $error("Target address changed under an invalid key.");

   a_addr_no_write: assert property ( // [R10]
      @(posedge CORE_CLK) disable iff (!RESET_N)
      !addr_wr |=> $stable(TARGET_ADDR))
      else $error("Target address changed without an address write.");

   a_addr_gated_pin1: assert property ( // [R11]
      @(posedge CORE_CLK) disable iff (!RESET_N)
      (addr_wr && key_q == 16'h84ad && !AUX_PIN_1) |=> $stable(TARGET_ADDR))
      else $error("Target address taken with pin 1 low.");

   a_addr_pin0_high: assert property ( // [R11]
      @(posedge CORE_CLK) disable iff (!RESET_N)
      (addr_wr && key_q == 16'h44ad && AUX_PIN_0)
      |=> (TARGET_ADDR == $past(REG_WDATA[7:1])))
      else $error("Target address refused with pin 0 high.");

   a_read_key: assert property (
      @(posedge CORE_CLK) disable iff (!RESET_N)
      (REG_ADDR == 8'h0d && !REG_WR) |=> (REG_RDATA == $past(key_q)))
      else $error("Key register read back wrong.");
endmodule

// *** tb/gam_host_model.sv ***
module gam_host_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic pin0,
   input wire logic pin1,
   output int rise0,
   output int rise1
);
   timeunit 1ns;
   timeprecision 1ps;
   logic last0;
   logic last1;
   // The host samples on its own edge, so a pulse shorter than a cycle is seen only if it spans that edge.
   always @(posedge clk) begin
      if (!rst_n) begin
         rise0 <= 0;
         rise1 <= 0;
      end else begin
         rise0 <= rise0 + int'(pin0 & ~last0);
         rise1 <= rise1 + int'(pin1 & ~last1);
      end
      last0 <= pin0;
      last1 <= pin1;
   end
endmodule

// *** tb/gam_pin_mux_tb_top.sv ***
module gam_pin_mux_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] addr = 8'h00;
   logic wr = 1'b0;
   logic [15:0] wdata = 16'h0000;
   logic leg_irq = 1'b0, leg_dout = 1'b0, cfg_irq = 1'b0, pol = 1'b0;
   logic first = 1'b0, last = 1'b0, pa = 1'b0, pb = 1'b0, da = 1'b0, db = 1'b0;
   logic strobe = 1'b0, osc = 1'b0;
   logic [15:0] rdata;
   logic pin0, pin1, p0, p1, v, ok, pl, x0, x1;
   logic [6:0] taddr, exp_addr;
   logic [4:0] c;
   logic [1:0] s, ki, mi;
   int rise0, rise1, r0, r1;
   int errors = 0;
   int checks = 0;
   logic [4:0] codes [14] = '{5'h00, 5'h01, 5'h05, 5'h06, 5'h07, 5'h0c, 5'h0d, 5'h0e,
                              5'h10, 5'h11, 5'h03, 5'h04, 5'h12, 5'h1f};
   logic [15:0] keys [4] = '{16'h04ad, 16'h44ad, 16'h84ad, 16'hc4ad};

   always #2.5 clk = ~clk;

   gam_pin_mux i_gam_pin_mux (
      .CORE_CLK(clk),
      .RESET_N(rst_n),
      .REG_ADDR(addr),
      .REG_WR(wr),
      .REG_WDATA(wdata),
      .REG_RDATA(rdata),
      .LEGACY_IRQ(leg_irq),
      .LEGACY_DATA_OUT(leg_dout),
      .CFG_IRQ(cfg_irq),
      .PIN0_POLARITY(pol),
      .FIRST_SLOT_START(first),
      .LAST_SLOT_END(last),
      .PULSE_A(pa),
      .PULSE_B(pb),
      .DATA_CYCLE_A(da),
      .DATA_CYCLE_B(db),
      .SAMPLE_STROBE(strobe),
      .OSC_32K(osc),
      .AUX_PIN_0(pin0),
      .AUX_PIN_1(pin1),
      .TARGET_ADDR(taddr)
   );

   gam_host_model i_gam_host_model (
      .clk(clk),
      .rst_n(rst_n),
      .pin0(pin0),
      .pin1(pin1),
      .rise0(rise0),
      .rise1(rise1)
   );

   task results;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task chk(input logic [15:0] got, input logic [15:0] exp, input string m);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   // Leaves wr high so a following write can be issued back to back.
   task wr_reg(input logic [7:0] a, input logic [15:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
   endtask

   task rd_chk(input logic [7:0] a, input logic [15:0] e, input string m);
      addr <= a;
      wr <= 1'b0;
      @(posedge clk);
      #1;
      chk(rdata, e, m);
      @(posedge clk);
   endtask

   task look(input logic e0, input logic e1, input string m);
      #1;
      chk(16'(pin0), 16'(e0), m);
      chk(16'(pin1), 16'(e1), m);
      @(posedge clk);
   endtask

   task chk_addr(input logic [6:0] e);
      #1;
      chk(16'(taddr), 16'(e), "target address");
      @(posedge clk);
   endtask

   function automatic logic exp_pin(input logic [4:0] k, input logic [1:0] p,
                                    input logic second, input logic inv);
      case (k)
         5'h00: exp_pin = second ? p[1] : p[0] ^ inv;
         5'h01: exp_pin = second ? p[1] : p[1] ^ inv;
         5'h05: exp_pin = p[0];
         5'h06: exp_pin = p[1];
         5'h07: exp_pin = |p;
         5'h0c: exp_pin = p[1];
         5'h0d: exp_pin = p[0];
         5'h0e: exp_pin = |p;
         5'h11: exp_pin = 1'b1;
         default: exp_pin = 1'b0;
      endcase
   endfunction

   initial begin
      repeat (6000) @(posedge clk);
      errors++;
      $display("[ERR] %0t watchdog expired", $time);
      results;
   end

   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      look(1'b0, 1'b0, "pins after reset");
      rd_chk(8'h0b, 16'h0000, "select reset");
      rd_chk(8'h0d, 16'h0000, "key reset");
      rd_chk(8'h09, 16'h0064, "address reset");
      rd_chk(8'h0c, 16'h0000, "unmapped read");
      $display("test reset done");
      for (int q = 0; q < 2; q++) begin
         pl = q[0];
         pol <= pl;
         for (int j = 0; j < 14; j++) begin
            c = codes[j];
            wr_reg(8'h0b, {3'b111, c, 3'b111, c});
            rd_chk(8'h0b, {3'b000, c, 3'b000, c}, "select readback");
            for (int p = 0; p < 4; p++) begin
               s = p[1:0];
               {leg_irq, leg_dout, cfg_irq, pa} <= {s[0], s[1], s[1], s[0]};
               {pb, da, db} <= {s[1], s[1], s[0]};
               @(posedge clk);
               x0 = exp_pin(c, s, 1'b0, pl);
               x1 = exp_pin(c, s, 1'b1, pl);
               look(x0, x1, "mux");
            end
         end
      end
      $display("test codes done");
      wr_reg(8'h0b, 16'h0202);
      wr <= 1'b0;
      first <= 1'b1;
      @(posedge clk);
      first <= 1'b0;
      look(1'b0, 1'b0, "window before");
      look(1'b1, 1'b1, "window open");
      look(1'b1, 1'b1, "window hold");
      last <= 1'b1;
      @(posedge clk);
      last <= 1'b0;
      look(1'b1, 1'b1, "window still");
      look(1'b0, 1'b0, "window closed");
      $display("test window done");
      wr_reg(8'h0b, 16'h0f0f);
      wr <= 1'b0;
      @(posedge clk);
      #1;
      p0 = pin0;
      p1 = pin1;
      r0 = rise0;
      r1 = rise1;
      @(posedge clk);
      for (int i = 0; i < 4; i++) begin
         strobe <= 1'b1;
         @(posedge clk);
         strobe <= 1'b0;
         look(~p0, ~p1, "toggle flip");
         look(~p0, ~p1, "toggle hold");
         p0 = ~p0;
         p1 = ~p1;
      end
      #1;
      chk(16'(rise0 - r0), 16'h0002, "pin 0 rises");
      chk(16'(rise1 - r1), 16'h0002, "pin 1 rises");
      @(posedge clk);
      $display("test toggle done");
      wr_reg(8'h0b, 16'h1313);
      wr <= 1'b0;
      repeat (4) @(posedge clk);
      for (int i = 1; i >= 0; i--) begin
         v = i[0];
         osc <= v;
         @(posedge clk);
         look(~v, ~v, "osc wait");
         look(~v, ~v, "osc wait");
         look(v, v, "osc follow");
      end
      $display("test oscillator done");
      exp_addr = 7'h32;
      wr_reg(8'h09, 16'had20);
      wr_reg(8'h0d, 16'h04ae);
      wr_reg(8'h09, 16'had22);
      wr <= 1'b0;
      @(posedge clk);
      chk_addr(exp_addr);
      for (int i = 0; i < 16; i++) begin
         ki = i[3:2];
         mi = i[1:0];
         wr_reg(8'h0b, {3'b000, 4'h8, mi[1], 3'b000, 4'h8, mi[0]});
         wr <= 1'b0;
         repeat (2) @(posedge clk);
         wr_reg(8'h0d, keys[ki]);
         wr_reg(8'h09, {8'had, 1'b1, ki, mi, 2'b01, 1'b0});
         ok = (ki == 2'd0) | ((ki == 2'd1) & mi[0]);
         ok = ok | ((ki == 2'd2) & mi[1]) | ((ki == 2'd3) & (&mi));
         if (ok) begin
            exp_addr = {1'b1, ki, mi, 2'b01};
         end
         wr <= 1'b0;
         @(posedge clk);
         chk_addr(exp_addr);
      end
      rd_chk(8'h09, {8'h00, exp_addr, 1'b0}, "address readback");
      rd_chk(8'h0d, 16'hc4ad, "key readback");
      $display("test unlock done");
      results;
   end
endmodule
